// [rtl/cuas_defines.vh]
// register offsets, field positions and reset values of the serial unit
`ifndef CUAS_DEFINES_VH
`define CUAS_DEFINES_VH
`define CUAS_A_BCR0    5'h00
`define CUAS_A_BCR1    5'h01
`define CUAS_A_POCR0   5'h02
`define CUAS_A_POCR2   5'h03
`define CUAS_A_POCR3   5'h04
`define CUAS_A_TMCR2   5'h05
`define CUAS_A_DIV     5'h06
`define CUAS_A_CMP     5'h07
`define CUAS_A_FSEL    5'h08
`define CUAS_A_FEN     5'h09
`define CUAS_A_MODE    5'h0A
`define CUAS_A_CTRL    5'h0B
`define CUAS_A_TXB     5'h0C
`define CUAS_A_RXB     5'h0D
`define CUAS_A_CCS     5'h0E
`define CUAS_A_CONV    5'h0F
`define CUAS_A_RAW     5'h10
`define CUAS_A_TCRC    5'h11
`define CUAS_A_RCRC    5'h12
`define CUAS_A_HSTAT   5'h13
`define CUAS_M_STOP_LEN_SELECT    3
`define CUAS_M_PRY     4
`define CUAS_M_PARITY_ON    5
`define CUAS_M_BIT_ORDER_SELECT   6
`define CUAS_M_IRS     7
`define CUAS_C_TE      0
`define CUAS_C_RE      1
`define CUAS_GMD_UART  2'h0
`define CUAS_GMD_HDLC  2'h2
`define CUAS_RST8      8'h00
`define CUAS_RST16     16'h0000
`define CUAS_CRC_INIT  16'hFFFF
`define CUAS_CRC_POLY  16'h1021
`define CUAS_F8_LAST   3'h7
`define CUAS_HBITS     4'h8
`endif

// [rtl/cuas_serial.v]
// asynchronous serial unit with hdlc data-processing conversion
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "cuas_defines.vh"
// Contract
// RULE1 - transfer clock is base clock over 2*(divisor+2)
// RULE2 - software keeps divisor between 0001 and FFFD hex
// RULE3 - software keeps transfer clock at base clock over six or slower
// RULE4 - on overrun the receive buffer content is undefined
// RULE5 - timer channel 3 phase-delayed output makes the transmit bit clock
// RULE6 - timer channel 2 output plus measurement makes receive clock, start aligned
// RULE7 - software keeps secondary compare below divisor
// RULE8 - five-bit prescale field divides the base timer count source
// RULE9 - stop select gives one or two stop bits, transmit and receive
// RULE10 - parity enable and odd/even select for transmit and receive
// RULE11 - bit order select gives lsb first or msb first
// RULE12 - interrupt source select picks the transmit event raising request
// RULE13 - control register shows transmit buffer empty and shift empty
// RULE14 - tx_enable enables transmit and is needed for receive
// RULE15 - 16-bit receive buffer with flags, 8-bit transmit buffer
// RULE16 - frame: start, eight data, optional parity, one or two stops
// RULE17 - overrun when next final stop arrives before buffer read
// RULE18 - hdlc mode stuffs, detects flag and abort, computes crc, no pins
// RULE19 - hdlc crc updates once per converted bit
// RULE20 - hdlc transmit stalls while converted output full, stuffing goes on
// RULE21 - hdlc receive stops when raw input register is empty
// RULE22 - hdlc clock picks f1, f8, prescaled or timer channel clock
// RULE23 - receiver samples mid-bit, framing error on low stop bit
module cuas_serial (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [4:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        serial_in_pin,
  output wire        serial_out_pin,
  output wire        tx_irq,
  output wire        rx_irq
);

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_DATA  = 5'h04;
  localparam [4:0] ST_PAR   = 5'h08;
  localparam [4:0] ST_STOP  = 5'h10;

  reg  [7:0]  bcr0_q, bcr1_q, pocr0_q, pocr2_q, pocr3_q, tmcr2_q;
  reg  [7:0]  fsel_q, fen_q, mode_q, ctrl_q, ccs_q;
  reg  [15:0] div_q, cmp_q;
  reg  [4:0]  psc_q;
  reg  [2:0]  f8_q;
  reg  [16:0] t3_q, t2_q;
  reg         r_ph_q;
  reg  [4:0]  tx_st_q;
  reg  [7:0]  tx_sh_q, tx_buf_q;
  reg  [2:0]  tx_cnt_q;
  reg         tx_par_q, tx_stop2_q, tx_out_q, tx_empty_q, tx_irq_q;
  reg  [7:0]  h_tsh_q, h_asm_q, conv_q;
  reg  [3:0]  h_tcnt_q, h_acnt_q;
  reg  [2:0]  h_ones_q;
  reg         conv_v_q;
  reg  [15:0] tcrc_q;
  reg  [4:0]  rx_st_q;
  reg  [7:0]  rx_sh_q;
  reg  [2:0]  rx_cnt_q;
  reg         rx_par_q, rx_stop2_q, rx_perr_q, rx_ferr_q;
  reg         rx_done_q, rx_irq_q, prev_in_q;
  reg  [15:0] rx_buf_q;
  reg  [7:0]  h_raw_q, h_rasm_q;
  reg  [3:0]  h_rcnt_q;
  reg  [2:0]  h_racnt_q, h_rones_q;
  reg         h_flag_q, h_abort_q;
  reg  [15:0] rcrc_q;
  reg  [15:0] rd_d;

  function [15:0] crc_step;
    input [15:0] c;
    input        b;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CUAS_CRC_POLY : `CUAS_RST16);
    end
  endfunction

  wire       uart_md   = (mode_q[1:0] == `CUAS_GMD_UART);
  wire       hdlc_md   = (mode_q[1:0] == `CUAS_GMD_HDLC);
  wire       te        = ctrl_q[`CUAS_C_TE];
  wire       re        = ctrl_q[`CUAS_C_RE];
  wire       stop_len_select      = mode_q[`CUAS_M_STOP_LEN_SELECT];
  wire       odd       = mode_q[`CUAS_M_PRY];
  wire       pon       = mode_q[`CUAS_M_PARITY_ON];
  wire       msb_first = mode_q[`CUAS_M_BIT_ORDER_SELECT];
  wire       irq_source_select       = mode_q[`CUAS_M_IRS];
  wire       wr_txb    = reg_wr && (reg_addr == `CUAS_A_TXB);
  wire       wr_raw    = reg_wr && (reg_addr == `CUAS_A_RAW);
  wire       rd_rxb    = reg_rd && (reg_addr == `CUAS_A_RXB);
  wire       rd_conv   = reg_rd && (reg_addr == `CUAS_A_CONV);
  wire       rd_hstat  = reg_rd && (reg_addr == `CUAS_A_HSTAT);

  // RULE8 prescaled count source
  wire        base_tick = (psc_q >= bcr0_q[4:0]);
  // RULE1 period of 2*(n+2) base ticks
  wire [16:0] t3_last   = {div_q, 1'b1} + 17'h00002;
  wire        t3_wrap   = (t3_q >= t3_last);
  // RULE5 phase-delayed edge at the secondary compare point
  wire        tx_tick   = base_tick && (t3_q == {1'b0, cmp_q});
  wire [16:0] t2_last   = {1'b0, div_q} + 17'h00001;
  wire        t2_wrap   = (t2_q >= t2_last);
  // RULE14 receive needs both enables
  wire        rx_on     = uart_md && te && re;
  wire        rx_restart = rx_on && (rx_st_q == ST_IDLE) && prev_in_q && !serial_in_pin;
  // RULE23 sample at the end of every odd half period
  wire        rx_samp   = base_tick && t2_wrap && !r_ph_q && !rx_restart;
  // RULE22 hdlc conversion clock select
  wire        hstep     = (ccs_q[1:0] == 2'h0) ? 1'b1 :
                          (ccs_q[1:0] == 2'h1) ? (f8_q == `CUAS_F8_LAST) :
                          (ccs_q[1:0] == 2'h2) ? base_tick : (base_tick && t3_wrap);
  // RULE11 next transmit data bit
  wire        tx_dbit   = msb_first ? tx_sh_q[7] : tx_sh_q[0];
  wire [7:0]  tx_shn    = msb_first ? {tx_sh_q[6:0], 1'b0} : {1'b0, tx_sh_q[7:1]};
  wire        tx_idle   = (tx_st_q == ST_IDLE) && (h_tcnt_q == 4'h0);
  wire        hr_bit    = h_raw_q[0];
  wire        hr_keep   = (h_rones_q < 3'h5);
  wire        rx_fin_f  = rx_ferr_q | ~serial_in_pin;

  assign serial_out_pin = tx_out_q;
  assign tx_irq         = tx_irq_q;
  assign rx_irq         = rx_irq_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bcr0_q  <= `CUAS_RST8;
      bcr1_q  <= `CUAS_RST8;
      pocr0_q <= `CUAS_RST8;
      pocr2_q <= `CUAS_RST8;
      pocr3_q <= `CUAS_RST8;
      tmcr2_q <= `CUAS_RST8;
      fsel_q  <= `CUAS_RST8;
      fen_q   <= `CUAS_RST8;
      mode_q  <= `CUAS_RST8;
      ctrl_q  <= `CUAS_RST8;
      ccs_q   <= `CUAS_RST8;
      div_q   <= `CUAS_RST16;
      cmp_q   <= `CUAS_RST16;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `CUAS_A_BCR0:  bcr0_q  <= reg_wdata[7:0];
        `CUAS_A_BCR1:  bcr1_q  <= reg_wdata[7:0];
        `CUAS_A_POCR0: pocr0_q <= reg_wdata[7:0];
        `CUAS_A_POCR2: pocr2_q <= reg_wdata[7:0];
        `CUAS_A_POCR3: pocr3_q <= reg_wdata[7:0];
        `CUAS_A_TMCR2: tmcr2_q <= reg_wdata[7:0];
        `CUAS_A_FSEL:  fsel_q  <= reg_wdata[7:0];
        `CUAS_A_FEN:   fen_q   <= reg_wdata[7:0];
        `CUAS_A_MODE:  mode_q  <= reg_wdata[7:0];
        `CUAS_A_CTRL:  ctrl_q  <= reg_wdata[7:0];
        `CUAS_A_CCS:   ccs_q   <= reg_wdata[7:0];
        `CUAS_A_DIV:   div_q   <= reg_wdata;
        `CUAS_A_CMP:   cmp_q   <= reg_wdata;
        default: ;
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `CUAS_A_BCR0:  rd_d = {8'h00, bcr0_q};
      `CUAS_A_BCR1:  rd_d = {8'h00, bcr1_q};
      `CUAS_A_POCR0: rd_d = {8'h00, pocr0_q};
      `CUAS_A_POCR2: rd_d = {8'h00, pocr2_q};
      `CUAS_A_POCR3: rd_d = {8'h00, pocr3_q};
      `CUAS_A_TMCR2: rd_d = {8'h00, tmcr2_q};
      `CUAS_A_FSEL:  rd_d = {8'h00, fsel_q};
      `CUAS_A_FEN:   rd_d = {8'h00, fen_q};
      `CUAS_A_MODE:  rd_d = {8'h00, mode_q};
      // RULE13 buffer-empty and shift-empty status
      `CUAS_A_CTRL:  rd_d = {8'h00, ctrl_q[7:5], tx_idle, tx_empty_q, rx_done_q, ctrl_q[1:0]};
      `CUAS_A_CCS:   rd_d = {8'h00, ccs_q};
      `CUAS_A_DIV:   rd_d = div_q;
      `CUAS_A_CMP:   rd_d = cmp_q;
      `CUAS_A_RXB:   rd_d = rx_buf_q;
      `CUAS_A_CONV:  rd_d = {8'h00, conv_q};
      `CUAS_A_TCRC:  rd_d = tcrc_q;
      `CUAS_A_RCRC:  rd_d = rcrc_q;
      `CUAS_A_HSTAT: rd_d = {12'h000, conv_v_q, (h_rcnt_q == 4'h0), h_abort_q, h_flag_q};
      default:       rd_d = `CUAS_RST16;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `CUAS_RST16;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_d : `CUAS_RST16;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      psc_q  <= 5'h00;
      f8_q   <= 3'h0;
      t3_q   <= 17'h00000;
      t2_q   <= 17'h00000;
      r_ph_q <= 1'b0;
    end else if (ce) begin
      psc_q <= base_tick ? 5'h00 : psc_q + 5'h01;
      f8_q  <= f8_q + 3'h1;
      if (base_tick) begin
        t3_q <= t3_wrap ? 17'h00000 : t3_q + 17'h00001;
      end
      // RULE6 receive timer restarts on the start edge
      if (rx_restart) begin
        t2_q   <= 17'h00000;
        r_ph_q <= 1'b0;
      end else if (base_tick) begin
        if (t2_wrap) begin
          t2_q   <= 17'h00000;
          r_ph_q <= ~r_ph_q;
        end else begin
          t2_q <= t2_q + 17'h00001;
        end
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q    <= ST_IDLE;
      tx_sh_q    <= `CUAS_RST8;
      tx_buf_q   <= `CUAS_RST8;
      tx_cnt_q   <= 3'h0;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
      tx_out_q   <= 1'b1;
      tx_empty_q <= 1'b1;
      tx_irq_q   <= 1'b0;
      h_tsh_q    <= `CUAS_RST8;
      h_asm_q    <= `CUAS_RST8;
      conv_q     <= `CUAS_RST8;
      h_tcnt_q   <= 4'h0;
      h_acnt_q   <= 4'h0;
      h_ones_q   <= 3'h0;
      conv_v_q   <= 1'b0;
      tcrc_q     <= `CUAS_CRC_INIT;
    end else if (ce) begin
      tx_irq_q <= 1'b0;
      if (rd_conv) begin
        conv_v_q <= 1'b0;
      end
      if (!te) begin
        tcrc_q <= `CUAS_CRC_INIT;
      end
      // RULE14 transmitter held idle unless enabled in uart mode
      if (!uart_md || !te) begin
        tx_st_q  <= ST_IDLE;
        tx_out_q <= 1'b1;
      end else if (tx_tick) begin
        // RULE16 start, data, parity, stop sequence
        case (tx_st_q)
          ST_IDLE: if (!tx_empty_q) begin
            tx_sh_q    <= tx_buf_q;
            tx_empty_q <= 1'b1;
            tx_out_q   <= 1'b0;
            tx_par_q   <= 1'b0;
            tx_st_q    <= ST_START;
            // RULE12 request on buffer transfer
            tx_irq_q   <= !irq_source_select;
          end
          ST_START: begin
            tx_out_q <= tx_dbit;
            tx_par_q <= tx_dbit;
            tx_sh_q  <= tx_shn;
            tx_cnt_q <= 3'h1;
            tx_st_q  <= ST_DATA;
          end
          ST_DATA: if (tx_cnt_q != 3'h0) begin
            tx_out_q <= tx_dbit;
            tx_par_q <= tx_par_q ^ tx_dbit;
            tx_sh_q  <= tx_shn;
            tx_cnt_q <= tx_cnt_q + 3'h1;
          // RULE10 parity bit generation
          end else if (pon) begin
            tx_out_q <= tx_par_q ^ odd;
            tx_st_q  <= ST_PAR;
          end else begin
            tx_out_q   <= 1'b1;
            tx_stop2_q <= stop_len_select;
            tx_st_q    <= ST_STOP;
          end
          ST_PAR: begin
            tx_out_q   <= 1'b1;
            tx_stop2_q <= stop_len_select;
            tx_st_q    <= ST_STOP;
          end
          // RULE9 one or two stop bits
          ST_STOP: if (tx_stop2_q) begin
            tx_stop2_q <= 1'b0;
          end else begin
            tx_st_q  <= ST_IDLE;
            tx_irq_q <= irq_source_select;
          end
          default: tx_st_q <= ST_IDLE;
        endcase
      end
      // RULE18 hdlc transmit conversion, no pin involved
      if (hdlc_md && te && hstep) begin
        if (h_acnt_q == `CUAS_HBITS) begin
          // RULE20 stall while converted output still full
          if (!conv_v_q) begin
            conv_q   <= h_asm_q;
            conv_v_q <= 1'b1;
            h_acnt_q <= 4'h0;
            tx_irq_q <= irq_source_select;
          end
        // RULE20 stuffing proceeds without further data
        end else if (h_ones_q == 3'h5) begin
          h_asm_q  <= {1'b0, h_asm_q[7:1]};
          h_acnt_q <= h_acnt_q + 4'h1;
          h_ones_q <= 3'h0;
        end else if (h_tcnt_q != 4'h0) begin
          h_asm_q  <= {h_tsh_q[0], h_asm_q[7:1]};
          h_acnt_q <= h_acnt_q + 4'h1;
          h_tsh_q  <= {1'b0, h_tsh_q[7:1]};
          h_tcnt_q <= h_tcnt_q - 4'h1;
          h_ones_q <= h_tsh_q[0] ? h_ones_q + 3'h1 : 3'h0;
          // RULE19 crc per converted bit
          tcrc_q   <= crc_step(tcrc_q, h_tsh_q[0]);
        end else if (!tx_empty_q) begin
          h_tsh_q    <= tx_buf_q;
          h_tcnt_q   <= `CUAS_HBITS;
          tx_empty_q <= 1'b1;
          tx_irq_q   <= !irq_source_select;
        end
      end
      // RULE15 eight-bit transmit buffer
      if (wr_txb) begin
        tx_buf_q   <= reg_wdata[7:0];
        tx_empty_q <= 1'b0;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q    <= ST_IDLE;
      rx_sh_q    <= `CUAS_RST8;
      rx_cnt_q   <= 3'h0;
      rx_par_q   <= 1'b0;
      rx_stop2_q <= 1'b0;
      rx_perr_q  <= 1'b0;
      rx_ferr_q  <= 1'b0;
      rx_done_q  <= 1'b0;
      rx_irq_q   <= 1'b0;
      prev_in_q  <= 1'b1;
      rx_buf_q   <= `CUAS_RST16;
      h_raw_q    <= `CUAS_RST8;
      h_rasm_q   <= `CUAS_RST8;
      h_rcnt_q   <= 4'h0;
      h_racnt_q  <= 3'h0;
      h_rones_q  <= 3'h0;
      h_flag_q   <= 1'b0;
      h_abort_q  <= 1'b0;
      rcrc_q     <= `CUAS_CRC_INIT;
    end else if (ce) begin
      rx_irq_q  <= 1'b0;
      prev_in_q <= serial_in_pin;
      if (rd_rxb) begin
        rx_done_q <= 1'b0;
      end
      if (rd_hstat) begin
        h_flag_q  <= 1'b0;
        h_abort_q <= 1'b0;
      end
      if (!re) begin
        rcrc_q <= `CUAS_CRC_INIT;
      end
      if (!rx_on) begin
        rx_st_q <= ST_IDLE;
      end else begin
        case (rx_st_q)
          ST_IDLE: if (rx_restart) begin
            rx_st_q <= ST_START;
          end
          // RULE23 false start rejected at mid-bit
          ST_START: if (rx_samp) begin
            if (serial_in_pin) begin
              rx_st_q <= ST_IDLE;
            end else begin
              rx_st_q   <= ST_DATA;
              rx_cnt_q  <= 3'h0;
              rx_par_q  <= 1'b0;
              rx_perr_q <= 1'b0;
              rx_ferr_q <= 1'b0;
            end
          end
          // RULE11 receive shift direction
          ST_DATA: if (rx_samp) begin
            rx_sh_q  <= msb_first ? {rx_sh_q[6:0], serial_in_pin}
                                  : {serial_in_pin, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ serial_in_pin;
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == 3'h7) begin
              rx_st_q    <= pon ? ST_PAR : ST_STOP;
              rx_stop2_q <= stop_len_select;
            end
          end
          // RULE10 parity check
          ST_PAR: if (rx_samp) begin
            rx_perr_q <= rx_par_q ^ serial_in_pin ^ odd;
            rx_st_q   <= ST_STOP;
          end
          ST_STOP: if (rx_samp) begin
            // RULE9 second stop bit also checked
            if (rx_stop2_q) begin
              rx_stop2_q <= 1'b0;
              rx_ferr_q  <= rx_fin_f;
            end else begin
              // RULE17 overrun when previous character unread
              // RULE4 overrun overwrites the buffer
              rx_buf_q  <= {rx_perr_q | rx_fin_f | rx_done_q, rx_perr_q,
                            rx_fin_f, rx_done_q, 4'h0, rx_sh_q};
              rx_done_q <= 1'b1;
              rx_irq_q  <= 1'b1;
              rx_st_q   <= ST_IDLE;
            end
          end
          default: rx_st_q <= ST_IDLE;
        endcase
      end
      // RULE21 receive conversion only while raw bits remain
      if (hdlc_md && te && re && hstep && (h_rcnt_q != 4'h0)) begin
        h_raw_q  <= {1'b0, h_raw_q[7:1]};
        h_rcnt_q <= h_rcnt_q - 4'h1;
        if (hr_keep) begin
          h_rasm_q  <= {hr_bit, h_rasm_q[7:1]};
          h_racnt_q <= h_racnt_q + 3'h1;
          // RULE19 receive crc per kept bit
          rcrc_q    <= crc_step(rcrc_q, hr_bit);
          if (h_racnt_q == 3'h7) begin
            rx_buf_q  <= {3'h0, rx_done_q, 4'h0, hr_bit, h_rasm_q[7:1]};
            rx_done_q <= 1'b1;
            rx_irq_q  <= 1'b1;
          end
        end
        // RULE18 flag and abort detection with destuffing
        if (hr_bit) begin
          if (h_rones_q == 3'h6) begin
            h_abort_q <= 1'b1;
          end
          if (h_rones_q != 3'h7) begin
            h_rones_q <= h_rones_q + 3'h1;
          end
        end else begin
          h_rones_q <= 3'h0;
          if (h_rones_q == 3'h6) begin
            h_flag_q  <= 1'b1;
            h_racnt_q <= 3'h0;
            rcrc_q    <= `CUAS_CRC_INIT;
          end
        end
      end
      if (wr_raw) begin
        h_raw_q  <= reg_wdata[7:0];
        h_rcnt_q <= `CUAS_HBITS;
      end
    end
  end

endmodule

// [bench/cuas_serial_chk.sv]
// port-level checker for the asynchronous serial unit
`timescale 1ns/1ns
`include "cuas_defines.vh"
module cuas_serial_chk (
  input wire        clock,
  input wire        rst_n,
  input wire        ce,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        serial_in_pin,
  input wire        serial_out_pin,
  input wire        tx_irq,
  input wire        rx_irq
);
  reg  [15:0] div_q;
  reg  [4:0]  pre_q;
  reg  [7:0]  mode_q;
  reg         te_q;
  reg         re_q;
  reg         last_q;
  reg  [31:0] run_q;
  wire [31:0] period_w;
  wire        uart_w;

  // shadow of the rate and mode registers, and length of the current line level
  assign period_w = 2 * (div_q + 2) * (pre_q + 1);
  assign uart_w = (mode_q[1:0] == `CUAS_GMD_UART);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
      pre_q <= 5'h00;
      mode_q <= 8'h00;
      te_q <= 1'b0;
      re_q <= 1'b0;
      last_q <= 1'b1;
      run_q <= 32'h0;
    end else if (ce) begin
      last_q <= serial_out_pin;
      run_q <= (serial_out_pin != last_q) ? 32'h1 : run_q + 32'h1;
      if (reg_wr && reg_addr == `CUAS_A_BCR0)
        pre_q <= reg_wdata[4:0];
      if (reg_wr && reg_addr == `CUAS_A_DIV)
        div_q <= reg_wdata;
      if (reg_wr && reg_addr == `CUAS_A_MODE)
        mode_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `CUAS_A_CTRL) begin
        te_q <= reg_wdata[`CUAS_C_TE];
        re_q <= reg_wdata[`CUAS_C_RE];
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read reply");
  a_unmapped_read: assert property (reg_rd && reg_addr > `CUAS_A_HSTAT |=> reg_rdata == 16'h0000)
    else $error("unmapped index returned data");
  a_txbuf_wo: assert property (reg_rd && reg_addr == `CUAS_A_TXB |=> reg_rdata == 16'h0000)
    else $error("transmit buffer readable");
  a_ctrl_upper_zero: assert property (reg_rd && reg_addr == `CUAS_A_CTRL |=> reg_rdata[15:8] == 8'h00)
    else $error("control register upper byte not zero");
  a_bit_width: assert property (serial_out_pin != last_q |-> run_q >= period_w)
    else $error("line level shorter than one bit period");
  a_idle_when_off: assert property (!te_q || !uart_w |=> serial_out_pin)
    else $error("line driven low while transmit is off or not in uart mode");
  a_rx_needs_en: assert property (!te_q || !re_q |=> !rx_irq)
    else $error("receive completion while receiver disabled");
  a_tx_irq_pulse: assert property (tx_irq |=> !tx_irq)
    else $error("transmit request longer than one cycle");
  a_rx_irq_pulse: assert property (rx_irq |=> !rx_irq)
    else $error("receive request longer than one cycle");
  a_irq_at_start: assert property (tx_irq && !mode_q[7] && uart_w |-> ##[0:1] !serial_out_pin)
    else $error("transfer request not at start bit");
  a_irq_at_end: assert property (tx_irq && mode_q[7] && uart_w |-> serial_out_pin ##1 serial_out_pin)
    else $error("completion request not at frame end");
endmodule

bind cuas_serial cuas_serial_chk u_cuas_serial_chk (
  .clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// [bench/cuas_peer.sv]
// remote serial peer: captures frames from the unit and injects frames into it
`timescale 1ns/1ns
module cuas_peer (
  input  wire        clock,
  input  wire        line_from_dut,
  input  wire [15:0] bit_clks,
  input  wire [3:0]  nbits,
  output reg         line_to_dut,
  output reg  [11:0] frame_q,
  output reg  [7:0]  frame_cnt
);
  initial begin
    line_to_dut = 1'b1;
    frame_q = 12'hFFF;
    frame_cnt = 8'h00;
  end

  always begin : mon
    integer i;
    reg [11:0] f;
    @(posedge clock);
    while (line_from_dut !== 1'b0)
      @(posedge clock);
    f = 12'hFFF;
    repeat (bit_clks / 2) @(posedge clock);
    for (i = 0; i < nbits; i = i + 1) begin
      f[i] = line_from_dut;
      if (i < nbits - 1)
        repeat (bit_clks) @(posedge clock);
    end
    frame_q <= f;
    frame_cnt <= frame_cnt + 8'h01;
  end

  // frame bits one period each, then an idle bit at the pull-up level
  task send(input [11:0] f, input [3:0] nb);
    integer i;
    for (i = 0; i < nb; i = i + 1) begin
      @(posedge clock);
      line_to_dut <= f[i];
      repeat (bit_clks - 16'h1) @(posedge clock);
    end
    @(posedge clock);
    line_to_dut <= 1'b1;
    repeat (bit_clks) @(posedge clock);
  endtask
endmodule

// [bench/test_comm_unit_async_serial.sv]
// self-checking bench for the asynchronous serial unit
`timescale 1ns/1ns
`include "cuas_defines.vh"
module test_comm_unit_async_serial;
  reg         clock;
  reg         rst_n;
  reg         ce;
  reg  [4:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [15:0] reg_rdata;
  wire        serial_in_pin;
  wire        serial_out_pin;
  wire        tx_irq;
  wire        rx_irq;
  reg  [15:0] bit_clks;
  reg  [3:0]  nbits;
  wire [11:0] frame_q;
  wire [7:0]  frame_cnt;
  reg  [15:0] rdv;
  integer     err_total;
  integer     n_tests;
  integer     cycles;

  cuas_serial u_cuas_serial (
    .clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq)
  );
  cuas_peer u_cuas_peer (
    .clock(clock), .line_from_dut(serial_out_pin), .bit_clks(bit_clks), .nbits(nbits),
    .line_to_dut(serial_in_pin), .frame_q(frame_q), .frame_cnt(frame_cnt)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles > 40000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end

  task finish_test;
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input [4:0] a, input [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task rd(input [4:0] a, output [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task wait_ctrl(input integer b, input v);
    integer k;
    k = 0;
    rd(`CUAS_A_CTRL, rdv);
    while (rdv[b] !== v && k < 300) begin
      rd(`CUAS_A_CTRL, rdv);
      k = k + 1;
    end
    chk({15'h0, rdv[b]}, {15'h0, v});
  endtask

  task wait_frame(input [7:0] c);
    integer k;
    k = 0;
    while (frame_cnt !== c && k < 3000) begin
      @(posedge clock);
      k = k + 1;
    end
    chk({8'h00, frame_cnt}, {8'h00, c});
  endtask

  // expected line bits, first bit in position 0, unused positions high
  function [11:0] mk_frame(input [7:0] d, input [7:0] m);
    integer i;
    begin
      mk_frame = 12'hFFF;
      mk_frame[0] = 1'b0;
      for (i = 0; i < 8; i = i + 1)
        mk_frame[i + 1] = m[6] ? d[7 - i] : d[i];
      if (m[5])
        mk_frame[9] = ^d ^ m[4];
    end
  endfunction

  task setup(input [7:0] m, input [15:0] n, input [4:0] pre);
    wr(`CUAS_A_CTRL, 16'h0000);
    wr(`CUAS_A_BCR0, {11'h000, pre});
    // divisor in range, compare below it
    wr(`CUAS_A_DIV, n);
    wr(`CUAS_A_CMP, 16'h0000);
    wr(`CUAS_A_MODE, {8'h00, m});
    bit_clks = 2 * (n + 2) * (pre + 1);
    nbits = 4'd10 + m[5] + m[3];
    wr(`CUAS_A_CTRL, 16'h0003);
    repeat (2 * bit_clks) @(posedge clock);
  endtask

  task t_reset;
    ce <= 1'b0;
    wr(`CUAS_A_CTRL, 16'h0003);
    ce <= 1'b1;
    rd(`CUAS_A_CTRL, rdv);
    chk(rdv, 16'h0018);
    rd(`CUAS_A_RXB, rdv);
    chk(rdv, 16'h0000);
    rd(`CUAS_A_TXB, rdv);
    chk(rdv, 16'h0000);
    rd(5'h1F, rdv);
    chk(rdv, 16'h0000);
    wr(`CUAS_A_MODE, {14'h0, `CUAS_GMD_HDLC});
    wr(`CUAS_A_CTRL, 16'h0003);
    wr(`CUAS_A_TXB, 16'h00A5);
    repeat (40) @(posedge clock);
    chk({15'h0, serial_out_pin}, 16'h0001);
    rd(`CUAS_A_CONV, rdv);
    chk(rdv, 16'h00A5);
    wr(`CUAS_A_CTRL, 16'h0000);
    wr(`CUAS_A_MODE, 16'h0000);
  endtask

  task t_tx(input [7:0] m, input [15:0] n, input [4:0] pre, input [7:0] d0, input [7:0] d1);
    reg [7:0] c;
    setup(m, n, pre);
    c = frame_cnt;
    wr(`CUAS_A_TXB, {8'h00, d0});
    wait_ctrl(3, 1'b1);
    wr(`CUAS_A_TXB, {8'h00, d1});
    wait_frame(c + 8'h01);
    chk({4'h0, frame_q}, {4'h0, mk_frame(d0, m)});
    wait_frame(c + 8'h02);
    chk({4'h0, frame_q}, {4'h0, mk_frame(d1, m)});
    wait_ctrl(4, 1'b1);
  endtask

  task t_rx(input [7:0] m, input [7:0] d, input [11:0] flip, input [3:0] ef);
    setup(m, 16'h0002, 5'h00);
    u_cuas_peer.send(mk_frame(d, m) ^ flip, nbits);
    wait_ctrl(2, 1'b1);
    rd(`CUAS_A_RXB, rdv);
    chk(rdv, {ef, 4'h0, d});
    rd(`CUAS_A_CTRL, rdv);
    chk({15'h0, rdv[2]}, 16'h0000);
  endtask

  task t_overrun;
    setup(8'h00, 16'h0002, 5'h00);
    u_cuas_peer.send(mk_frame(8'h11, 8'h00), nbits);
    u_cuas_peer.send(mk_frame(8'h22, 8'h00), nbits);
    rd(`CUAS_A_RXB, rdv);
    // data byte left unchecked, its content is undefined after an overrun
    chk(rdv & 16'hF000, 16'h9000);
  endtask

  task t_rx_off;
    setup(8'h00, 16'h0002, 5'h00);
    wr(`CUAS_A_CTRL, 16'h0001);
    u_cuas_peer.send(mk_frame(8'h3C, 8'h00), nbits);
    rd(`CUAS_A_CTRL, rdv);
    chk({15'h0, rdv[2]}, 16'h0000);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bit_clks = 16'h0008;
    nbits = 4'd10;
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_tx(8'h00, 16'h0002, 5'h00, 8'hA5, 8'h3C);
    t_tx(8'h28, 16'h0002, 5'h00, 8'h0F, 8'hF0);
    t_tx(8'h70, 16'h0002, 5'h00, 8'h96, 8'h01);
    t_tx(8'hF8, 16'h0001, 5'h01, 8'h80, 8'h7E);
    t_tx(8'h40, 16'h0001, 5'h00, 8'hC3, 8'h5A);
    t_rx(8'h00, 8'h5A, 12'h000, 4'h0);
    t_rx(8'h28, 8'hC3, 12'h000, 4'h0);
    t_rx(8'h70, 8'h96, 12'h000, 4'h0);
    t_rx(8'h30, 8'h96, 12'h200, 4'hC);
    t_rx(8'h00, 8'h7E, 12'h200, 4'hA);
    t_rx(8'h08, 8'h7E, 12'h400, 4'hA);
    t_overrun;
    t_rx_off;
    finish_test;
  end
endmodule
